// file: core/systmr_top.sv
// System timer with two 52-bit counters, three alarm comparators and an APB register file.
//
// How it works
// R01: three independent 52-bit comparators, own alarms.
// R02: mode bit one repeats, zero one-shot.
// R03: repeating alarms at start plus each interval.
// R04: one-shot target from 32 and 20 bits.
// R05: source bit picks counter one or zero.
// R06: no comparing until comparator run is set.
// R07: recently passed target alarms at once; the code does so only when count and target share the top bit.
// R08: far-passed target waits for wrap and equality.
// R09: staged values adopted only on sync strobe.
// R10: software writes fields before the strobe.
// R11: level alarm stays high until cleared.
// R12: alarm reaches output only when enabled.
// R13: software keeps units running while configuring.
// R14: snapshot, poll ready, then read halves.
// R15: one-shot setup order is software's job.
// R16: repeating setup order is software's job.
// R17: software rescales sleep ticks into the preset.
// R18: counter sync replaces count with preset.
// R19: count tick alternates three and two cycles.
// R20: running counter steps each tick, else holds.
// R21: halt-follow pauses counter during processor stall.
// R22: snapshot latches count, then ready flag.
// R23: interval start is count at run or sync.
// R24: raw flag, enable gating, write-one clear.
`timescale 1ns/10ps
`default_nettype none
`include "systmr_defs.svh"
module systmr_top (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic cpu_stall_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic [2:0] alarm_irq_out
);
  systmr_pkg::systmr_top_s s_q;
  systmr_pkg::systmr_top_s s_d;
  systmr_pkg::systmr_cfg_s [2:0] cfg;
  logic [2:0] fire;
  logic [2:0] csync;
  logic [1:0] usync;
  logic [1:0] upd;
  logic [1:0] vclr;
  logic [2:0] iclr;
  logic tick;
  logic wr;
  logic setup;
  logic [31:0] rd;
  logic hit;

  // Fractional divider: ticks after three cycles, then after two.
  assign tick = s_q.div == (s_q.ph ? `SYSTMR_DIV_B : `SYSTMR_DIV_A); // R19
  assign setup = psel_in & ~penable_in;
  // A write lands at the access edge, when ready is already high.
  assign wr = psel_in & penable_in & pwrite_in & s_q.rdy;

  // Decode of the strobe-type writes.
  always_comb begin
    csync = '0;
    usync = '0;
    upd = '0;
    vclr = '0;
    iclr = '0;
    if (wr) begin
      case (paddr_in)
        `SYSTMR_OFS_CSYN0: csync[0] = pwdata_in[`SYSTMR_B_SYNC];
        `SYSTMR_OFS_CSYN1: csync[1] = pwdata_in[`SYSTMR_B_SYNC];
        `SYSTMR_OFS_CSYN2: csync[2] = pwdata_in[`SYSTMR_B_SYNC];
        `SYSTMR_OFS_USYN0: usync[0] = pwdata_in[`SYSTMR_B_SYNC];
        `SYSTMR_OFS_USYN1: usync[1] = pwdata_in[`SYSTMR_B_SYNC];
        `SYSTMR_OFS_OP0: begin
          upd[0] = pwdata_in[`SYSTMR_B_UPDATE];
          vclr[0] = pwdata_in[`SYSTMR_B_VALID];
        end
        `SYSTMR_OFS_OP1: begin
          upd[1] = pwdata_in[`SYSTMR_B_UPDATE];
          vclr[1] = pwdata_in[`SYSTMR_B_VALID];
        end
        `SYSTMR_OFS_ICLR: iclr = pwdata_in[2:0]; // R24
        default: iclr = '0;
      endcase
    end
  end

  // Read data and address check, prepared during the setup cycle.
  always_comb begin
    rd = '0;
    hit = 1'b1;
    case (paddr_in)
      `SYSTMR_OFS_CONF: begin
        rd[`SYSTMR_B_CLKEN] = s_q.clk_en;
        rd[`SYSTMR_B_URUN -: 2] = {s_q.urun[0], s_q.urun[1]};
        rd[`SYSTMR_B_USTL -: 2] = {s_q.ustl[0], s_q.ustl[1]};
        rd[`SYSTMR_B_CRUN -: 3] = {s_q.crun[0], s_q.crun[1], s_q.crun[2]};
      end
      `SYSTMR_OFS_OP0: rd[`SYSTMR_B_VALID] = s_q.valid[0];
      `SYSTMR_OFS_OP1: rd[`SYSTMR_B_VALID] = s_q.valid[1];
      `SYSTMR_OFS_LDHI0: rd[`SYSTMR_HW-1:0] = s_q.pre[0][51:32];
      `SYSTMR_OFS_LDLO0: rd = s_q.pre[0][31:0];
      `SYSTMR_OFS_LDHI1: rd[`SYSTMR_HW-1:0] = s_q.pre[1][51:32];
      `SYSTMR_OFS_LDLO1: rd = s_q.pre[1][31:0];
      `SYSTMR_OFS_TGHI0: rd[`SYSTMR_HW-1:0] = s_q.tgt[0][51:32];
      `SYSTMR_OFS_TGLO0: rd = s_q.tgt[0][31:0];
      `SYSTMR_OFS_TGHI1: rd[`SYSTMR_HW-1:0] = s_q.tgt[1][51:32];
      `SYSTMR_OFS_TGLO1: rd = s_q.tgt[1][31:0];
      `SYSTMR_OFS_TGHI2: rd[`SYSTMR_HW-1:0] = s_q.tgt[2][51:32];
      `SYSTMR_OFS_TGLO2: rd = s_q.tgt[2][31:0];
      `SYSTMR_OFS_TCF0: rd = {s_q.sel[0], s_q.rep[0], 4'h0, s_q.ivl[0]};
      `SYSTMR_OFS_TCF1: rd = {s_q.sel[1], s_q.rep[1], 4'h0, s_q.ivl[1]};
      `SYSTMR_OFS_TCF2: rd = {s_q.sel[2], s_q.rep[2], 4'h0, s_q.ivl[2]};
      `SYSTMR_OFS_VHI0: rd[`SYSTMR_HW-1:0] = s_q.snap[0][51:32]; // R14
      `SYSTMR_OFS_VLO0: rd = s_q.snap[0][31:0];
      `SYSTMR_OFS_VHI1: rd[`SYSTMR_HW-1:0] = s_q.snap[1][51:32];
      `SYSTMR_OFS_VLO1: rd = s_q.snap[1][31:0];
      `SYSTMR_OFS_CSYN0, `SYSTMR_OFS_CSYN1, `SYSTMR_OFS_CSYN2: rd = '0;
      `SYSTMR_OFS_USYN0, `SYSTMR_OFS_USYN1, `SYSTMR_OFS_ICLR: rd = '0;
      `SYSTMR_OFS_IENA: rd[2:0] = s_q.ena;
      `SYSTMR_OFS_IRAW: rd[2:0] = s_q.raw;
      `SYSTMR_OFS_IST: rd[2:0] = s_q.raw & s_q.ena;
      `SYSTMR_OFS_DATE: rd = `SYSTMR_DATE_VAL; // Arbitrary version value.
      default: hit = 1'b0;
    endcase
  end

  // Comparator configuration: live mode bits, staged target and interval.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      cfg[i].run = s_q.crun[i];
      cfg[i].rep = s_q.rep[i]; // R02
      cfg[i].tgt = s_q.tgt[i];
      cfg[i].ivl = s_q.ivl[i];
    end
  end

  // Three identical comparators, each watching its chosen counter.
  for (genvar g = 0; g < 3; g++) begin : g_cmp
    systmr_comparator u_cmp (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .cfg_in(cfg[g]),
      .count_in(s_q.cnt[s_q.sel[g]]), // R05
      .sync_in(csync[g]), // R09
      .fire_out(fire[g])
    ); // R01
  end

  // Next state of the whole block.
  always_comb begin
    s_d = s_q;
    // Divider phase toggles on every tick.
    if (tick) begin
      s_d.div = '0;
      s_d.ph = ~s_q.ph;
    end else begin
      s_d.div = s_q.div + 2'h1;
    end
    // Stall pin passes two flops before use.
    s_d.stl = {s_q.stl[0], cpu_stall_in};
    // Bus answer: ready and data in the access cycle after setup.
    s_d.rdy = setup;
    s_d.err = setup & ~hit;
    s_d.rdata = setup ? rd : '0;
    // Register writes into staged copies and control bits.
    if (wr) begin
      case (paddr_in)
        `SYSTMR_OFS_CONF: begin
          s_d.clk_en = pwdata_in[`SYSTMR_B_CLKEN];
          s_d.urun = {pwdata_in[`SYSTMR_B_URUN-1], pwdata_in[`SYSTMR_B_URUN]};
          s_d.ustl = {pwdata_in[`SYSTMR_B_USTL-1], pwdata_in[`SYSTMR_B_USTL]};
          s_d.crun = {pwdata_in[`SYSTMR_B_CRUN-2], pwdata_in[`SYSTMR_B_CRUN-1], pwdata_in[`SYSTMR_B_CRUN]};
        end
        `SYSTMR_OFS_LDHI0: s_d.pre[0][51:32] = pwdata_in[`SYSTMR_HW-1:0]; // R09
        `SYSTMR_OFS_LDLO0: s_d.pre[0][31:0] = pwdata_in;
        `SYSTMR_OFS_LDHI1: s_d.pre[1][51:32] = pwdata_in[`SYSTMR_HW-1:0];
        `SYSTMR_OFS_LDLO1: s_d.pre[1][31:0] = pwdata_in;
        `SYSTMR_OFS_TGHI0: s_d.tgt[0][51:32] = pwdata_in[`SYSTMR_HW-1:0]; // R04
        `SYSTMR_OFS_TGLO0: s_d.tgt[0][31:0] = pwdata_in;
        `SYSTMR_OFS_TGHI1: s_d.tgt[1][51:32] = pwdata_in[`SYSTMR_HW-1:0];
        `SYSTMR_OFS_TGLO1: s_d.tgt[1][31:0] = pwdata_in;
        `SYSTMR_OFS_TGHI2: s_d.tgt[2][51:32] = pwdata_in[`SYSTMR_HW-1:0];
        `SYSTMR_OFS_TGLO2: s_d.tgt[2][31:0] = pwdata_in;
        `SYSTMR_OFS_TCF0: begin
          s_d.ivl[0] = pwdata_in[`SYSTMR_IW-1:0];
          s_d.rep[0] = pwdata_in[`SYSTMR_B_REP];
          s_d.sel[0] = pwdata_in[`SYSTMR_B_SEL];
        end
        `SYSTMR_OFS_TCF1: begin
          s_d.ivl[1] = pwdata_in[`SYSTMR_IW-1:0];
          s_d.rep[1] = pwdata_in[`SYSTMR_B_REP];
          s_d.sel[1] = pwdata_in[`SYSTMR_B_SEL];
        end
        `SYSTMR_OFS_TCF2: begin
          s_d.ivl[2] = pwdata_in[`SYSTMR_IW-1:0];
          s_d.rep[2] = pwdata_in[`SYSTMR_B_REP];
          s_d.sel[2] = pwdata_in[`SYSTMR_B_SEL];
        end
        `SYSTMR_OFS_IENA: s_d.ena = pwdata_in[2:0]; // R12
        default: s_d.ena = s_q.ena;
      endcase
    end
    // Counters: preset load first, else step on a tick while running.
    for (int u = 0; u < 2; u++) begin
      if (usync[u]) begin
        s_d.cnt[u] = s_q.pre[u]; // R18
      end else if (tick && s_q.urun[u] && !(s_q.ustl[u] && s_q.stl[1])) begin // R21
        s_d.cnt[u] = s_q.cnt[u] + `SYSTMR_CW'(1); // R20
      end
      // Snapshot: a new capture sets ready, beating a clear in the same write.
      if (vclr[u]) begin
        s_d.valid[u] = 1'b0;
      end
      if (upd[u]) begin
        s_d.snap[u] = s_q.cnt[u]; // R22
        s_d.valid[u] = 1'b1;
      end
    end
    // Sticky alarm flags: an alarm beats a clear arriving in the same cycle.
    s_d.raw = (s_q.raw & ~iclr) | fire; // R11 R24
    s_d.irq = s_d.raw & s_d.ena; // R12
  end

  // State register.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata_out = s_q.rdata;
  assign pready_out = s_q.rdy;
  assign pslverr_out = s_q.err;
  assign alarm_irq_out = s_q.irq;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // Tick pattern: gaps of three then two cycles.
  sequence s_gap3;
    !tick ##1 !tick ##1 tick;
  endsequence
  sequence s_gap2;
    !tick ##1 tick;
  endsequence
  a_tick_pattern: assert property (tick && !s_q.ph |=> s_gap2 ##1 s_gap3) else $error("tick spacing wrong"); // R19
  a_count_step: assert property (tick && s_q.urun[0] && !s_q.ustl[0] && !usync[0]
    |=> s_q.cnt[0] == $past(s_q.cnt[0]) + `SYSTMR_CW'(1)) else $error("counter did not step"); // R20
  a_count_hold: assert property (!s_q.urun[1] && !usync[1] |=> $stable(s_q.cnt[1])) else $error("stopped counter moved"); // R20
  a_stall_hold: assert property (s_q.urun[0] && s_q.ustl[0] && s_q.stl[1] && !usync[0]
    |=> $stable(s_q.cnt[0])) else $error("counter ran during stall"); // R21
  a_preset_load: assert property (usync[0] |=> s_q.cnt[0] == $past(s_q.pre[0])) else $error("preset not loaded"); // R18
  a_snap_ready: assert property (upd[1] |=> s_q.valid[1] && s_q.snap[1] == $past(s_q.cnt[1])) else $error("snapshot wrong"); // R22
  a_irq_sticky: assert property (fire[0] ##1 !iclr[0] [*2] |-> s_q.raw[0]) else $error("alarm flag dropped"); // R11
  a_irq_gate: assert property (##1 alarm_irq_out == $past(s_d.raw & s_d.ena)) else $error("alarm output not gated"); // R12 R24
  a_bus_answer: assert property (setup |=> pready_out ##1 !pready_out || setup) else $error("bus answer timing"); // R09
endmodule // systmr_top
`default_nettype wire

// file: core/systmr_defs.svh
// Widths, offsets, field positions and timing counts of the system timer alarm block.
`ifndef SYSTMR_DEFS_SVH
`define SYSTMR_DEFS_SVH
`define SYSTMR_CW 52
`define SYSTMR_IW 26
`define SYSTMR_HW 20
`define SYSTMR_HALF_M1 52'h7_ffff_ffff_ffff
`define SYSTMR_OFS_CONF 8'h00
`define SYSTMR_OFS_OP0 8'h04
`define SYSTMR_OFS_OP1 8'h08
`define SYSTMR_OFS_LDHI0 8'h0c
`define SYSTMR_OFS_LDLO0 8'h10
`define SYSTMR_OFS_LDHI1 8'h14
`define SYSTMR_OFS_LDLO1 8'h18
`define SYSTMR_OFS_TGHI0 8'h1c
`define SYSTMR_OFS_TGLO0 8'h20
`define SYSTMR_OFS_TGHI1 8'h24
`define SYSTMR_OFS_TGLO1 8'h28
`define SYSTMR_OFS_TGHI2 8'h2c
`define SYSTMR_OFS_TGLO2 8'h30
`define SYSTMR_OFS_TCF0 8'h34
`define SYSTMR_OFS_TCF1 8'h38
`define SYSTMR_OFS_TCF2 8'h3c
`define SYSTMR_OFS_VHI0 8'h40
`define SYSTMR_OFS_VLO0 8'h44
`define SYSTMR_OFS_VHI1 8'h48
`define SYSTMR_OFS_VLO1 8'h4c
`define SYSTMR_OFS_CSYN0 8'h50
`define SYSTMR_OFS_CSYN1 8'h54
`define SYSTMR_OFS_CSYN2 8'h58
`define SYSTMR_OFS_USYN0 8'h5c
`define SYSTMR_OFS_USYN1 8'h60
`define SYSTMR_OFS_IENA 8'h64
`define SYSTMR_OFS_IRAW 8'h68
`define SYSTMR_OFS_ICLR 8'h6c
`define SYSTMR_OFS_IST 8'h70
`define SYSTMR_OFS_DATE 8'hfc
`define SYSTMR_B_CLKEN 31
`define SYSTMR_B_URUN 30
`define SYSTMR_B_USTL 28
`define SYSTMR_B_CRUN 24
`define SYSTMR_B_UPDATE 30
`define SYSTMR_B_VALID 29
`define SYSTMR_B_SEL 31
`define SYSTMR_B_REP 30
`define SYSTMR_B_SYNC 0
`define SYSTMR_DIV_A 2'h2
`define SYSTMR_DIV_B 2'h1
`define SYSTMR_DATE_VAL 32'h0000_0001
`endif

// file: core/systmr_pkg.sv
// Types shared by the system timer alarm block.
`include "systmr_defs.svh"
package systmr_pkg;
  // Configuration seen by one comparator.
  typedef struct packed {
    logic run;
    logic rep;
    logic [`SYSTMR_CW-1:0] tgt;
    logic [`SYSTMR_IW-1:0] ivl;
  } systmr_cfg_s;
  // Working state of one comparator.
  typedef struct packed {
    logic [`SYSTMR_CW-1:0] tgt;
    logic [`SYSTMR_IW-1:0] ivl;
    logic [`SYSTMR_CW-1:0] nxt;
    logic done;
    logic run_p;
    logic rep_p;
  } systmr_cmp_s;
  // Working state of the whole block.
  typedef struct packed {
    logic clk_en;
    logic [1:0] urun;
    logic [1:0] ustl;
    logic [2:0] crun;
    logic [1:0][`SYSTMR_CW-1:0] pre;
    logic [1:0][`SYSTMR_CW-1:0] cnt;
    logic [1:0][`SYSTMR_CW-1:0] snap;
    logic [1:0] valid;
    logic [2:0][`SYSTMR_CW-1:0] tgt;
    logic [2:0][`SYSTMR_IW-1:0] ivl;
    logic [2:0] rep;
    logic [2:0] sel;
    logic [2:0] ena;
    logic [2:0] raw;
    logic [2:0] irq;
    logic [31:0] rdata;
    logic rdy;
    logic err;
    logic [1:0] div;
    logic ph;
    logic [1:0] stl;
  } systmr_top_s;
endpackage

// file: core/systmr_comparator.sv
// One 52-bit alarm comparator with one-shot and repeating operation.
`timescale 1ns/10ps
`default_nettype none
`include "systmr_defs.svh"
module systmr_comparator (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire systmr_pkg::systmr_cfg_s cfg_in,
  input wire logic [`SYSTMR_CW-1:0] count_in,
  input wire logic sync_in,
  output logic fire_out
);
  systmr_pkg::systmr_cmp_s s_q;
  systmr_pkg::systmr_cmp_s s_d;
  logic [`SYSTMR_CW-1:0] ref_v;
  logic [`SYSTMR_CW-1:0] diff;
  logic armed;

  // Compare only once run has stood a cycle, so the start point is settled first.
  assign armed = cfg_in.run & s_q.run_p & ~(cfg_in.rep & ~s_q.rep_p); // R06
  assign ref_v = cfg_in.rep ? s_q.nxt : s_q.tgt;
  assign diff = count_in - ref_v;
  // A reached point fires, a recently passed one only if its top bit matches the count's; a far one waits for the wrap.
  assign fire_out = armed & ~s_q.done & (diff < `SYSTMR_HALF_M1)
    & (count_in[`SYSTMR_CW-1] == ref_v[`SYSTMR_CW-1]); // R07 R08

  // Next state: advance the interval sum, latch sync values, restart on run.
  always_comb begin
    s_d = s_q;
    s_d.run_p = cfg_in.run;
    s_d.rep_p = cfg_in.rep;
    if (fire_out) begin
      if (cfg_in.rep) begin
        s_d.nxt = s_q.nxt + `SYSTMR_CW'(s_q.ivl); // R03
      end else begin
        s_d.done = 1'b1; // R04
      end
    end
    if (sync_in) begin
      s_d.tgt = cfg_in.tgt; // R09
      s_d.ivl = cfg_in.ivl;
      s_d.done = 1'b0;
    end
    if ((sync_in & cfg_in.run) | (cfg_in.run & ~s_q.run_p) | (cfg_in.rep & ~s_q.rep_p)) begin
      s_d.nxt = count_in + `SYSTMR_CW'(s_d.ivl); // R23
      s_d.done = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_idle_quiet: assert property (!cfg_in.run |-> !fire_out) else $error("alarm while stopped"); // R06
  a_one_shot: assert property (fire_out && !cfg_in.rep && !sync_in && $stable(cfg_in)
    |=> !fire_out) else $error("one-shot alarm repeated"); // R04
  a_interval_step: assert property (fire_out && cfg_in.rep && !sync_in && s_q.run_p
    |=> s_q.nxt == $past(s_q.nxt) + `SYSTMR_CW'($past(s_q.ivl))) else $error("interval sum wrong"); // R03
  a_far_waits: assert property (armed && !s_q.done && !cfg_in.rep
    && (count_in - s_q.tgt) >= `SYSTMR_HALF_M1 |-> !fire_out) else $error("far target fired"); // R08
endmodule // systmr_comparator
`default_nettype wire

// file: verif/systmr_tb.sv
// Self-checking testbench of the system timer alarm block.
`timescale 1ns/10ps
`default_nettype none
`include "systmr_defs.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module testbench;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic stall = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic rdy;
  logic err;
  logic [2:0] irq;
  logic [31:0] conf = 32'h0;
  logic last_err;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;

  // Design under test.
  systmr_top i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .paddr_in(pa), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .pwdata_in(pwd), .cpu_stall_in(stall),
    .prdata_out(prd), .pready_out(rdy), .pslverr_out(err), .alarm_irq_out(irq));

  // Clock of 10 ns period.
  always #5 clk_in = ~clk_in;

  // Cycle count, which also cuts a hang short.
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      end_sim();
    end
  end

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One APB transfer: setup, then access held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_in);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    // Ready sampled high ends this wait; if it never comes, only the bench timeout does.
    do begin
      @(posedge clk_in);
    end while (rdy !== 1'b1);
    r = prd;
    last_err = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h0, r);
  endtask

  task automatic cf(input int b, input logic v);
    conf[b] = v;
    wr(`SYSTMR_OFS_CONF, conf);
  endtask

  // Snapshot of counter u, polled until ready; t is the cycle of the strobe.
  task automatic snap(input int u, output logic [51:0] v, output int t);
    logic [31:0] r;
    logic [31:0] lo;
    int n;
    wr(`SYSTMR_OFS_OP0 + 8'(4 * u), 32'h4000_0000);
    t = cyc;
    n = 0;
    do begin
      rd(`SYSTMR_OFS_OP0 + 8'(4 * u), r);
      n++;
    end while (r[`SYSTMR_B_VALID] !== 1'b1 && n < 10);
    rd(`SYSTMR_OFS_VLO0 + 8'(8 * u), lo);
    rd(`SYSTMR_OFS_VHI0 + 8'(8 * u), r);
    v = {r[19:0], lo};
  endtask

  // Preset halves first, the counter strobe last.
  task automatic preset(input int u, input logic [51:0] v);
    wr(`SYSTMR_OFS_LDHI0 + 8'(8 * u), {12'h0, v[51:32]});
    wr(`SYSTMR_OFS_LDLO0 + 8'(8 * u), v[31:0]);
    wr(`SYSTMR_OFS_USYN0 + 8'(4 * u), 32'h1);
  endtask

  // Comparator conf and target halves first, the comparator strobe last.
  task automatic arm(input int x, input logic [51:0] v, input logic [31:0] c);
    wr(`SYSTMR_OFS_TCF0 + 8'(4 * x), c);
    wr(`SYSTMR_OFS_TGHI0 + 8'(8 * x), {12'h0, v[51:32]});
    wr(`SYSTMR_OFS_TGLO0 + 8'(8 * x), v[31:0]);
    wr(`SYSTMR_OFS_CSYN0 + 8'(4 * x), 32'h1);
  endtask

  task automatic wait_irq(input int b, input int lim, output int t);
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (irq[b] !== 1'b1 && n < lim);
    t = cyc;
  endtask

  // Reset values, staged readback and an unmapped address.
  task automatic t_regs();
    logic [31:0] r;
    rd(`SYSTMR_OFS_CONF, r);
    `CHK("conf", 32'h0, r)
    wr(`SYSTMR_OFS_TGHI0, 32'hffff_ffff);
    rd(`SYSTMR_OFS_TGHI0, r);
    `CHK("tghi", 32'h000f_ffff, r)
    rd(8'h80, r);
    `CHK("unmapped", 1'b1, last_err)
    `CHK("unmapped rd", 32'h0, r)
  endtask

  // Preset, hold while stopped, tick rate while running, ready clear.
  task automatic t_count();
    logic [51:0] v1;
    logic [51:0] v2;
    logic [31:0] r;
    int t1;
    int t2;
    int e;
    preset(0, 52'h1_2345_6789_abcd);
    snap(0, v1, t1);
    `CHK("preset", 52'h1_2345_6789_abcd, v1)
    repeat (20) @(posedge clk_in);
    snap(0, v1, t1);
    `CHK("hold", 52'h1_2345_6789_abcd, v1)
    wr(`SYSTMR_OFS_OP0, 32'h2000_0000);
    rd(`SYSTMR_OFS_OP0, r);
    `CHK("ready clr", 1'b0, r[29])
    cf(30, 1'b1);
    snap(0, v1, t1);
    repeat (100) @(posedge clk_in);
    snap(0, v2, t2);
    e = (t2 - t1) * 2 / 5;
    `CHK("rate", 1'b1, (v2 - v1 >= e - 1) && (v2 - v1 <= e + 1))
    preset(0, 52'h8_0000_0000_0000);
    snap(0, v1, t1);
    `CHK("reload", 1'b1, (v1 >= 52'h8_0000_0000_0000) && (v1 < 52'h8_0000_0000_0008))
    // Three slow ticks of an 80 kHz sleep clock become 1500 count ticks.
    snap(0, v1, t1);
    preset(0, v1 + 52'(3 * 500));
    snap(0, v2, t2);
    `CHK("sleep", 1'b1, (v2 >= v1 + 52'd1500) && (v2 < v1 + 52'd1508))
  endtask

  // Halt-follow pauses the counter during a processor stall.
  task automatic t_stall();
    logic [51:0] a;
    logic [51:0] b;
    int t;
    cf(28, 1'b1);
    stall <= 1'b1;
    repeat (5) @(posedge clk_in);
    snap(0, a, t);
    repeat (50) @(posedge clk_in);
    snap(0, b, t);
    `CHK("stalled", a, b)
    stall <= 1'b0;
    repeat (50) @(posedge clk_in);
    snap(0, a, t);
    `CHK("resumed", 1'b1, a > b)
    cf(28, 1'b0);
  endtask

  // One-shot: run gating, passed target, enable gating, clear, future target.
  task automatic t_oneshot();
    logic [51:0] c;
    logic [31:0] r;
    int ts;
    int t;
    snap(0, c, ts);
    arm(0, c - 52'd5, 32'h0);
    repeat (20) @(posedge clk_in);
    rd(`SYSTMR_OFS_IRAW, r);
    `CHK("no run", 32'h0, r)
    cf(24, 1'b1);
    repeat (5) @(posedge clk_in);
    rd(`SYSTMR_OFS_IRAW, r);
    `CHK("passed", 32'h1, r)
    `CHK("masked", 3'h0, irq)
    wr(`SYSTMR_OFS_IENA, 32'h1);
    repeat (2) @(posedge clk_in);
    `CHK("enabled", 3'h1, irq)
    wr(`SYSTMR_OFS_ICLR, 32'h1);
    repeat (30) @(posedge clk_in);
    `CHK("cleared", 3'h0, irq)
    snap(0, c, ts);
    arm(0, c + 52'd60, 32'h0);
    `CHK("early", 3'h0, irq)
    wait_irq(0, 400, t);
    `CHK("late", 1'b1, (t - ts >= 146) && (t - ts <= 158))
    wr(`SYSTMR_OFS_ICLR, 32'h1);
    cf(24, 1'b0);
  endtask

  // Far-passed target on counter 1 waits for the wrap.
  task automatic t_wrap();
    logic [51:0] v;
    int ts;
    int t;
    cf(29, 1'b1);
    preset(1, 52'hf_ffff_ffff_ff00);
    ts = cyc;
    arm(1, 52'h10, 32'h8000_0000);
    wr(`SYSTMR_OFS_IENA, 32'h2);
    cf(23, 1'b1);
    repeat (40) @(posedge clk_in);
    `CHK("no early", 3'h0, irq)
    // A passed target written without the strobe must not be adopted.
    wr(`SYSTMR_OFS_TGHI1, 32'h000f_ffff);
    wr(`SYSTMR_OFS_TGLO1, 32'hffff_ff00);
    repeat (5) @(posedge clk_in);
    `CHK("staged", 3'h0, irq)
    wait_irq(1, 1000, t);
    `CHK("wrap time", 1'b1, (t - ts >= 670) && (t - ts <= 690))
    snap(1, v, t);
    `CHK("source", 1'b1, (v >= 52'h10) && (v < 52'h30))
    cf(23, 1'b0);
    wr(`SYSTMR_OFS_ICLR, 32'h2);
  endtask

  // Repeating alarms every interval from the start point.
  task automatic t_repeat();
    int ts;
    int t0;
    int t1;
    int t2;
    logic [31:0] r;
    arm(2, 52'h0, 32'h0000_0014);
    wr(`SYSTMR_OFS_TCF2, 32'h4000_0014);
    cf(22, 1'b1);
    ts = cyc;
    wr(`SYSTMR_OFS_IENA, 32'h4);
    wait_irq(2, 200, t0);
    `CHK("start", 1'b1, (t0 - ts >= 46) && (t0 - ts <= 55))
    wr(`SYSTMR_OFS_ICLR, 32'h4);
    wait_irq(2, 200, t1);
    wr(`SYSTMR_OFS_ICLR, 32'h4);
    wait_irq(2, 200, t2);
    `CHK("period 1", 50, t1 - t0)
    `CHK("period 2", 50, t2 - t1)
    rd(`SYSTMR_OFS_IRAW, r);
    `CHK("others", 2'h0, r[1:0])
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_count();
    t_stall();
    t_oneshot();
    t_wrap();
    t_repeat();
    end_sim();
  end
endmodule // testbench
`default_nettype wire
